// >>> src/sat_cfg.svh
// Register map, field positions and reset values of the serial unit.
// Included by every design file that decodes or builds register data.
`ifndef SAT_CFG_SVH
`define SAT_CFG_SVH

// ==========================================================
// Register byte offsets
`define SAT_ADDR_MODE    8'h00
`define SAT_ADDR_SHIFT   8'h04
`define SAT_ADDR_PTR     8'h08
`define SAT_ADDR_STAT    8'h0c
`define SAT_ADDR_PRESC   8'h10
`define SAT_BUF_BIT      7

// ==========================================================
// Mode register fields
`define SAT_MODE_EN      7
`define SAT_MODE_DIR     6
`define SAT_MODE_AUTO    5
`define SAT_MODE_CLK_HI  1
`define SAT_MODE_CLK_LO  0
`define SAT_MODE_MASK    8'he3

// ==========================================================
// Reset values and counts
`define SAT_MODE_RST     8'h00
`define SAT_PTR_RST      8'h00
`define SAT_PRESC_RST    8'h88
`define SAT_PRESC_OFS    4'h5
`define SAT_LAST_BIT     4'h7
`define SAT_WORD_BITS    4'h8

`endif

// >>> src/sat_pkg.sv
// Types shared by the serial unit.
// Assumes the including design reads names as sat_pkg::name.
package sat_pkg;

	// Block sequencer states, Gray along idle, shift, next
	typedef enum logic [1:0] {
		SAT_ST_IDLE  = 2'b00,
		SAT_ST_SHIFT = 2'b01,
		SAT_ST_NEXT  = 2'b11
	} sat_state_t;

endpackage

// >>> src/sat_clkgen.sv
// Serial clock generation and edge detection for the serial unit.
// Assumes timer_tick and sck_in are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "sat_cfg.svh"

module sat_clkgen (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Control
	input  wire logic       enable,
	input  wire logic       run,
	input  wire logic [1:0] src,
	input  wire logic [3:0] presc_code,
	input  wire logic       timer_tick,
	// Serial clock pin
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe_n,
	// Edge enables
	output logic            fall_en,
	output logic            rise_en
);

	logic [7:0] cnt_q, cnt_d;
	logic       sck_q, sck_d;
	logic       sin_q, sin_d;
	logic [3:0] k;
	logic [7:0] mask;
	logic       presc_tick;
	logic       src_tick;

	// ==========================================================
	// Prescaler: divides hclk by a power of two
	always_comb begin
		k          = presc_code - `SAT_PRESC_OFS;
		mask       = 8'((9'h001 << k) - 9'h001);
		presc_tick = (cnt_q & mask) == mask;
		cnt_d      = cnt_q + 8'h01;
	end

	// ==========================================================
	// Source choice and edges
	always_comb begin
		src_tick = src[1] ? (src[0] ? presc_tick : timer_tick) : 1'b0;
		sin_d    = sck_in;
		sck_d    = sck_q;
		if (!run)
			sck_d = 1'b1;
		else if (src_tick)
			sck_d = ~sck_q;
		if (src[1]) begin
			fall_en = run & src_tick & sck_q;
			rise_en = run & src_tick & ~sck_q;
		end else begin
			fall_en = run & sin_q & ~sck_in;
			rise_en = run & ~sin_q & sck_in;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 8'h00;
			sck_q <= 1'b1;
			sin_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			sck_q <= sck_d;
			sin_q <= sin_d;
		end
	end

	assign sck_out  = sck_q;
	assign sck_oe_n = ~(enable & src[1]);

endmodule
`default_nettype wire

// >>> src/sat_shifter.sv
// Eight-bit shift register with bit counter for the serial unit.
// Assumes fall_en and rise_en are one-cycle pulses of the serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "sat_cfg.svh"

module sat_shifter (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Control
	input  wire logic       clear,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	input  wire logic       lsb_first,
	input  wire logic       fall_en,
	input  wire logic       rise_en,
	// Serial lines
	input  wire logic       serial_in,
	output logic            serial_out,
	// Status
	output logic [7:0]      shift_data,
	output logic            active,
	output logic            done
);

	logic [7:0] sr_q, sr_d;
	logic [3:0] cnt_q, cnt_d;
	logic       act_q, act_d;
	logic       so_q, so_d;
	logic       done_q, done_d;

	// ==========================================================
	// Shift and count
	always_comb begin
		sr_d   = sr_q;
		cnt_d  = cnt_q;
		act_d  = act_q;
		so_d   = so_q;
		done_d = 1'b0;
		if (clear) begin
			cnt_d = 4'h0;
			act_d = 1'b0;
		end else if (load) begin
			sr_d  = load_data;
			cnt_d = 4'h0;
			act_d = 1'b1;
			so_d  = lsb_first ? load_data[0] : load_data[7];
		end else if (act_q) begin
			if (fall_en)
				so_d = lsb_first ? sr_q[0] : sr_q[7];
			if (rise_en) begin
				sr_d  = lsb_first ? {serial_in, sr_q[7:1]}
				                  : {sr_q[6:0], serial_in};
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `SAT_LAST_BIT) begin
					act_d  = 1'b0;
					done_d = 1'b1;
				end
			end
		end
	end

	// Data register deliberately has no reset
	always_ff @(posedge hclk) begin
		sr_q <= sr_d;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q  <= 4'h0;
			act_q  <= 1'b0;
			so_q   <= 1'b1;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			act_q  <= act_d;
			so_q   <= so_d;
			done_q <= done_d;
		end
	end

	assign serial_out = so_q;
	assign shift_data = sr_q;
	assign active     = act_q;
	assign done       = done_q;

endmodule
`default_nettype wire

// >>> src/sat_top.sv
// Three-wire serial unit with automatic block transfer, AHB-Lite slave.
// Assumes a single AHB-Lite master; pins are synchronous to hclk.
//
// Overview of operation
// - Three modes: stopped, plain three-wire, three-wire with block transfer.
// - Stopped mode does no transfer and holds shifting logic idle.
// - Plain mode moves 8-bit words over clock, out and in lines.
// - Bits are shifted out and in at the same time.
// - First bit is MSB or LSB by configuration, in both modes.
// - Block mode moves up to 32 bytes with one start.
// - Block transfer is sequenced by hardware, no per-byte software.
// - An 8-bit shift register converts, one bit per serial clock.
// - Writing the shift register starts only with enable bit 7 set.
// - Written data goes out; sampled input gathers in same register.
// - Reset leaves the shift register undefined.
// - Pointer holds count minus 1, decrementing after each byte but the last.
// - Reset clears the pointer to zero.
// - A counter counts serial clocks and spots a whole word.
// - Mode bit 5 at 0 selects plain, 1 selects block transfer.
// - Clock select: external, timer output, or prescaled system clock.
// - Block in progress flag marks the block end for software.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sat_cfg.svh"

module sat_top #(
	parameter int BUF_DEPTH = 32
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Serial lines
	input  wire logic        serial_clock_line_in,
	output logic             serial_clock_line_out,
	output logic             serial_clock_line_oe_n,
	output logic             serial_out_line,
	input  wire logic        serial_in_line,
	// Timer and request
	input  wire logic        eight_bit_timer_two,
	output logic             byte_done_irq
);

	logic [7:0]  mode_q, mode_d;
	logic [7:0]  ptr_q, ptr_d;
	logic [7:0]  presc_q, presc_d;
	logic        trf_q, trf_d;
	logic        wr_q, wr_d;
	logic [7:0]  addr_q, addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	sat_pkg::sat_state_t state_q, state_d;
	logic [7:0]  buf_mem [BUF_DEPTH];
	logic        addr_ph;
	logic        en, lsb, auto;
	logic        sw_shift, start;
	logic        sh_load, sh_active, sh_done;
	logic [7:0]  sh_load_data, sh_data;
	logic        fall_en, rise_en;
	logic        cap;
	logic [4:0]  idx;

	assign en   = mode_q[`SAT_MODE_EN];
	assign lsb  = mode_q[`SAT_MODE_DIR];
	assign auto = mode_q[`SAT_MODE_AUTO];
	assign idx  = ptr_q[4:0];

	// ==========================================================
	// AHB-Lite slave: zero wait states, always OKAY
	assign addr_ph   = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	always_comb begin
		wr_d     = addr_ph & hwrite;
		addr_d   = addr_ph ? haddr[7:0] : addr_q;
		hrdata_d = hrdata_q;
		if (addr_ph && !hwrite) begin
			hrdata_d = 32'h0000_0000;
			if (haddr[`SAT_BUF_BIT])
				hrdata_d[7:0] = buf_mem[haddr[6:2]];
			else
				unique case (haddr[7:0])
					`SAT_ADDR_MODE:  hrdata_d[7:0] = mode_q;
					`SAT_ADDR_SHIFT: hrdata_d[7:0] = sh_data;
					`SAT_ADDR_PTR:   hrdata_d[7:0] = ptr_q;
					`SAT_ADDR_STAT:  hrdata_d[1:0] = {sh_active, trf_q};
					`SAT_ADDR_PRESC: hrdata_d[7:0] = presc_q;
					default:         hrdata_d = 32'h0000_0000;
				endcase
		end
	end

	// ==========================================================
	// Registers and block sequencer
	assign sw_shift = wr_q && (addr_q == `SAT_ADDR_SHIFT);
	assign start    = sw_shift && en && (state_q == sat_pkg::SAT_ST_IDLE);

	always_comb begin
		mode_d       = mode_q;
		ptr_d        = ptr_q;
		presc_d      = presc_q;
		trf_d        = trf_q;
		state_d      = state_q;
		sh_load      = 1'b0;
		sh_load_data = hwdata[7:0];
		cap          = 1'b0;
		if (wr_q && !addr_q[`SAT_BUF_BIT]) begin
			if (addr_q == `SAT_ADDR_MODE)
				mode_d = hwdata[7:0] & `SAT_MODE_MASK;
			if (addr_q == `SAT_ADDR_PRESC)
				presc_d = hwdata[7:0];
			if (addr_q == `SAT_ADDR_PTR && !trf_q)
				ptr_d = hwdata[7:0];
		end
		unique case (state_q)
			sat_pkg::SAT_ST_IDLE: begin
				if (start) begin
					sh_load = 1'b1;
					state_d = sat_pkg::SAT_ST_SHIFT;
					if (auto) begin
						sh_load_data = buf_mem[idx];
						trf_d        = 1'b1;
					end
				end
			end
			sat_pkg::SAT_ST_SHIFT: begin
				if (sh_done) begin
					if (!trf_q)
						state_d = sat_pkg::SAT_ST_IDLE;
					else begin
						cap = 1'b1;
						if (ptr_q == 8'h00) begin
							trf_d   = 1'b0;
							state_d = sat_pkg::SAT_ST_IDLE;
						end else begin
							ptr_d   = ptr_q - 8'h01;
							state_d = sat_pkg::SAT_ST_NEXT;
						end
					end
				end
			end
			sat_pkg::SAT_ST_NEXT: begin
				sh_load      = 1'b1;
				sh_load_data = buf_mem[idx];
				state_d      = sat_pkg::SAT_ST_SHIFT;
			end
			default: state_d = sat_pkg::SAT_ST_IDLE;
		endcase
		if (!en) begin
			state_d = sat_pkg::SAT_ST_IDLE;
			trf_d   = 1'b0;
			sh_load = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q   <= `SAT_MODE_RST;
			ptr_q    <= `SAT_PTR_RST;
			presc_q  <= `SAT_PRESC_RST;
			trf_q    <= 1'b0;
			state_q  <= sat_pkg::SAT_ST_IDLE;
			wr_q     <= 1'b0;
			addr_q   <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			mode_q   <= mode_d;
			ptr_q    <= ptr_d;
			presc_q  <= presc_d;
			trf_q    <= trf_d;
			state_q  <= state_d;
			wr_q     <= wr_d;
			addr_q   <= addr_d;
			hrdata_q <= hrdata_d;
		end
	end

	// Block buffer: received byte replaces the byte just sent
	always_ff @(posedge hclk) begin
		if (cap)
			buf_mem[idx] <= sh_data;
		else if (wr_q && addr_q[`SAT_BUF_BIT])
			buf_mem[addr_q[6:2]] <= hwdata[7:0];
	end

	// ==========================================================
	// Clock generator and shifter
	sat_clkgen u_clkgen (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.enable     (en),
		.run        (sh_active),
		.src        (mode_q[`SAT_MODE_CLK_HI:`SAT_MODE_CLK_LO]),
		.presc_code (presc_q[7:4]),
		.timer_tick (eight_bit_timer_two),
		.sck_in     (serial_clock_line_in),
		.sck_out    (serial_clock_line_out),
		.sck_oe_n   (serial_clock_line_oe_n),
		.fall_en    (fall_en),
		.rise_en    (rise_en)
	);

	sat_shifter u_shifter (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.clear      (!en),
		.load       (sh_load),
		.load_data  (sh_load_data),
		.lsb_first  (lsb),
		.fall_en    (fall_en),
		.rise_en    (rise_en),
		.serial_in  (serial_in_line),
		.serial_out (serial_out_line),
		.shift_data (sh_data),
		.active     (sh_active),
		.done       (sh_done)
	);

	assign byte_done_irq = sh_done;

	// ==========================================================
	// Checks
	logic [3:0] rc_q, rc_d;

	always_comb begin
		rc_d = rc_q;
		if (sh_load)
			rc_d = 4'h0;
		else if (rise_en && sh_active)
			rc_d = rc_q + 4'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rc_q <= 4'h0;
		else
			rc_q <= rc_d;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_stop_idle;
		!en |=> !sh_active && !trf_q;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("shifter active while channel stopped");

	property p_no_start_disabled;
		sw_shift && !en |=> state_q == sat_pkg::SAT_ST_IDLE && !sh_active;
	endproperty
	a_no_start_disabled: assert property (p_no_start_disabled)
		else $error("transfer started with channel disabled");

	property p_load_plain;
		start && !auto |=> sh_data == $past(hwdata[7:0]) && sh_active;
	endproperty
	a_load_plain: assert property (p_load_plain)
		else $error("written byte not loaded into shift register");

	property p_first_bit;
		start && !auto && lsb |=> serial_out_line == $past(hwdata[0]);
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("first bit not the least significant one");

	property p_ptr_dec;
		sh_done && trf_q && en && ptr_q != 8'h00
			|=> ptr_q == $past(ptr_q) - 8'h01
			##1 sh_active;
	endproperty
	a_ptr_dec: assert property (p_ptr_dec)
		else $error("pointer not decremented or next byte not started");

	property p_block_end;
		sh_done && trf_q && ptr_q == 8'h00 |=> !trf_q && !sh_active;
	endproperty
	a_block_end: assert property (p_block_end)
		else $error("block flag still set after last byte");

	property p_word_len;
		sh_done |-> rc_q == `SAT_WORD_BITS;
	endproperty
	a_word_len: assert property (p_word_len)
		else $error("word did not take eight serial clocks");

	property p_irq_pulse;
		byte_done_irq |=> !byte_done_irq && !sh_active;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("done request longer than one cycle");

endmodule
`default_nettype wire

// >>> verif/sat_peer.sv
// Behavioural display peripheral on the far side of the serial lines.
// Assumes the wire levels are sampled on hclk; it drives the clock on start.
`timescale 1ns/1ps
`default_nettype none

module sat_peer #(
	parameter int HALF = 5
) (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Serial wire levels
	input  wire logic       sck,
	input  wire logic       so,
	output logic            si,
	// External clock drive
	input  wire logic       start,
	output logic            sck_drv,
	output logic            drv_en,
	// Frame data
	input  wire logic [7:0] tx_base,
	output logic [7:0]      n_frames
);
	logic       sck_q;
	logic       in_frame;
	logic [2:0] nb;
	logic [7:0] rx_sr;
	logic [7:0] tx_cur;
	logic [7:0] rx_log [0:63];
	int         hcnt;
	int         edges;

	assign tx_cur = tx_base + n_frames;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_q    <= 1'b1;
			in_frame <= 1'b0;
			nb       <= 3'h0;
			n_frames <= 8'h00;
			si       <= 1'b0;
			sck_drv  <= 1'b1;
			drv_en   <= 1'b0;
			hcnt     <= 0;
			edges    <= 0;
		end else begin
			sck_q <= sck;
			// Eight clocks of HALF cycles per phase, idling high
			if (start && !drv_en) begin
				drv_en <= 1'b1;
				hcnt   <= 0;
				edges  <= 0;
			end else if (drv_en) begin
				hcnt <= (hcnt == HALF - 1) ? 0 : hcnt + 1;
				if (hcnt == HALF - 1) begin
					sck_drv <= ~sck_drv;
					edges   <= edges + 1;
					drv_en  <= (edges != 15);
				end
			end
			// Next bit on falling edges, changing pattern between frames
			if (sck_q && !sck) begin
				si       <= tx_cur[3'h7 - nb];
				in_frame <= 1'b1;
			end else if (!in_frame) begin
				si <= ~si;
			end
			if (!sck_q && sck) begin
				rx_sr <= {rx_sr[6:0], so};
				nb    <= nb + 3'h1;
				if (nb == 3'h7) begin
					rx_log[n_frames[5:0]] <= {rx_sr[6:0], so};
					n_frames              <= n_frames + 8'h01;
					in_frame              <= 1'b0;
				end
			end
		end
	end
endmodule

`default_nettype wire

// >>> verif/sat_tb_top.sv
// Self-checking bench for the serial unit with its display peripheral.
// Assumes one AHB-Lite master with zero-wait slave and a pulled-up clock.
`timescale 1ns/1ps
`default_nettype none
`include "sat_cfg.svh"

module sat_tb_top;
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] presc;
		logic [7:0] tx;
		logic [7:0] ptx;
	} sat_row_t;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hrdy;
	logic        hresp;
	logic [31:0] hrdata;
	logic        sck_o;
	logic        sck_oe_n;
	logic        sck_w;
	logic        so;
	logic        si;
	logic        tick;
	logic [1:0]  tcnt;
	logic        p_sck;
	logic        p_en;
	logic        p_start;
	logic [7:0]  p_base;
	logic [7:0]  p_nf;
	logic        irq;
	logic        irq_q;
	logic [31:0] d;
	logic [7:0]  f0;
	logic        lsb;
	int          n0;
	int          n_fail;
	int          n_compared;
	int          n_irq;
	sat_row_t    rows [6];

	assign sck_w = !sck_oe_n ? sck_o : (p_en ? p_sck : 1'b1);

	sat_top uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
		.serial_clock_line_in(sck_w), .serial_clock_line_out(sck_o),
		.serial_clock_line_oe_n(sck_oe_n), .serial_out_line(so),
		.serial_in_line(si), .eight_bit_timer_two(tick),
		.byte_done_irq(irq)
	);

	sat_peer peer (
		.hclk(hclk), .hresetn(hresetn), .sck(sck_w), .so(so), .si(si),
		.start(p_start), .sck_drv(p_sck), .drv_en(p_en),
		.tx_base(p_base), .n_frames(p_nf)
	);

	// ==========================================================
	// Clock, timer ticks and request monitor
	always #10 hclk = ~hclk;

	always @(posedge hclk) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end

	always @(negedge hclk) begin
		if (irq === 1'b1)
			n_irq++;
		if (irq === 1'b1 && irq_q === 1'b1)
			chk("irq width", 0, 1);
		irq_q = irq;
	end

	// ==========================================================
	// Tasks
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rdy;
		for (int i = 0; i < 50; i++) begin
			@(posedge hclk);
			if (hrdy === 1'b1)
				return;
		end
		chk("hready", 1, 0);
		end_of_test;
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] v);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		rdy;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		rdy;
	endtask

	task automatic rc(input string nm, input logic [31:0] a,
			input logic [31:0] e);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		rdy;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		rdy;
		d = hrdata;
		chk(nm, e, d);
		chk("hresp", 0, hresp);
	endtask

	task automatic wirq(input int t);
		for (int i = 0; i < 3000 && n_irq < t; i++)
			@(negedge hclk);
		if (n_irq < t) begin
			chk("irq count", t, n_irq);
			end_of_test;
		end
		// Peer logs the last bit a cycle after the request on an internal clock, in the same cycle on the external one, so wait for it
		repeat (2) @(posedge hclk);
	endtask

	function automatic logic [7:0] rev(input logic [7:0] v);
		return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		rows = '{'{8'h83, 8'h70, 8'ha5, 8'h3c}, '{8'hc3, 8'h70, 8'h81, 8'h96},
			'{8'h82, 8'h88, 8'h5a, 8'hf0}, '{8'hc2, 8'h88, 8'h01, 8'h80},
			'{8'h80, 8'h88, 8'hc3, 8'h2d}, '{8'hc1, 8'h88, 8'h7e, 8'h11}};
		{hclk, hsel, hwrite, p_start, irq_q} = 5'h0;
		{haddr, hwdata} = 64'h0;
		{htrans, tcnt, tick, p_base} = 13'h0;
		{n_fail, n_compared, n_irq} = 0;
		hresetn = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		chk("sck reset", 32'he, {sck_o, sck_oe_n, so, irq});
		rc("mode reset", `SAT_ADDR_MODE, 0);
		rc("ptr reset", `SAT_ADDR_PTR, 0);
		rc("presc reset", `SAT_ADDR_PRESC, 32'h88);
		rc("stat reset", `SAT_ADDR_STAT, 0);
		wr(32'h14, 8'hff);
		rc("unmapped", 32'h14, 0);
		$display("test reset done");
		for (int r = 0; r < 6; r++) begin
			lsb = rows[r].mode[6];
			f0 = p_nf;
			n0 = n_irq;
			wr(`SAT_ADDR_PRESC, rows[r].presc);
			wr(`SAT_ADDR_MODE, rows[r].mode);
			p_base <= rows[r].ptx - f0;
			wr(`SAT_ADDR_SHIFT, rows[r].tx);
			if (!rows[r].mode[1]) begin
				p_start <= 1'b1;
				@(posedge hclk);
				p_start <= 1'b0;
			end
			wirq(n0 + 1);
			chk("peer rx", lsb ? rev(rows[r].tx) : rows[r].tx,
				peer.rx_log[f0[5:0]]);
			rc("shift rx", `SAT_ADDR_SHIFT,
				lsb ? rev(rows[r].ptx) : rows[r].ptx);
			chk("sck idle", 1, sck_w);
			$display("test row %0d done", r);
		end
		wr(`SAT_ADDR_MODE, 8'h03);
		n0 = n_irq;
		wr(`SAT_ADDR_SHIFT, 8'h55);
		repeat (300) @(negedge hclk);
		chk("refused irq", n0, n_irq);
		chk("refused sck", 1, sck_w);
		$display("test refused start done");
		wr(`SAT_ADDR_PRESC, 8'h70);
		for (int i = 0; i < 3; i++)
			wr(32'h80 + 4 * i, 8'h11 * (i + 1));
		wr(`SAT_ADDR_PTR, 8'h02);
		wr(`SAT_ADDR_MODE, 8'ha3);
		f0 = p_nf;
		p_base <= 8'h40 - f0;
		n0 = n_irq;
		// No shift or pointer writes are needed until the block ends
		wr(`SAT_ADDR_SHIFT, 8'h00);
		wirq(n0 + 1);
		rc("ptr dec", `SAT_ADDR_PTR, 1);
		wr(`SAT_ADDR_PTR, 8'h1f);
		rc("ptr kept", `SAT_ADDR_PTR, 1);
		// Mid-byte of the second transfer: block flag and shifting both set
		rc("blk flag", `SAT_ADDR_STAT, 32'h3);
		wirq(n0 + 3);
		rc("blk end", `SAT_ADDR_STAT, 0);
		rc("ptr end", `SAT_ADDR_PTR, 0);
		for (int k = 0; k < 3; k++) begin
			chk("blk tx", 8'h11 * (3 - k), peer.rx_log[f0[5:0] + k]);
			rc("blk rx", 32'h80 + 4 * (2 - k), 8'h40 + k);
		end
		$display("test block done");
		wr(`SAT_ADDR_PTR, 8'h05);
		n0 = n_irq;
		wr(`SAT_ADDR_SHIFT, 8'h00);
		wirq(n0 + 1);
		wr(`SAT_ADDR_MODE, 8'h00);
		rc("abort stat", `SAT_ADDR_STAT, 0);
		n0 = n_irq;
		repeat (300) @(negedge hclk);
		chk("abort irq", n0, n_irq);
		chk("abort sck", 3, {sck_w, sck_oe_n});
		$display("test abort done");
		end_of_test;
	end
endmodule

`default_nettype wire
